// [design/headroom_pkg.sv]
// package: register map, field layout, timing and types of the headroom loop
//--------------------------------------------------------------------------
// What this block does
// R1 - only channels detected in use join the headroom comparison
// R2 - per-channel enable mask excludes unused strings from regulation
// R3 - sink voltages sampled once per period, one decision per period
// R4 - any monitored channel below low band asks to raise the rail
// R5 - rail lowered only when every monitored channel exceeds high band
// R6 - band thresholds programmable, high 0.25V-0.6V, low 0.2V-0.55V
// R7 - software should pick 0.45-0.55V above 150mA, else 0.3-0.4V
// R8 - starting rail setting comes from one-time memory value; code loads the bus-writable ctrl init field instead
// R9 - role strap low selects master, high selects slave
// R10 - only master moves the rail, slave only reports its demand
// R11 - feedback input 0.75V-1.2V sets raise flag, clears lower flag
// R12 - feedback input below 0.3V sets lower flag, clears raise flag
// R13 - feedback input 0.3V-0.75V clears both flags, meaning hold
// R14 - slave drives 1V on raise, 0V on lower, else 0.5V
// R15 - master steps divider down on raise demand so rail rises
// R16 - master steps divider up only on full lower demand, else holds
// R17 - page 0 address is 3 times strap b level plus strap a level
// R18 - page 1 address is 8 plus that, both ground gives 1000
// R19 - straps sampled once at start-up, address held until reset
// R20 - systems above 9 devices must set page bit on some devices
// R21 - strap and window codes synchronised and debounced before use
// R22 - divider setting is saturating counter, one step per period
//--------------------------------------------------------------------------
package headroom_pkg;

  // register byte addresses (indices times four, modulo 256)
  localparam int          IDX_CHAN_EN   = 3;
  localparam int          IDX_BAND      = 39;
  localparam int          IDX_CTRL      = 64;
  localparam int          IDX_STATUS    = 65;
  localparam logic [7:0]  ADDR_CHAN_EN  = 8'(IDX_CHAN_EN * 4);
  localparam logic [7:0]  ADDR_BAND     = 8'(IDX_BAND * 4);
  localparam logic [7:0]  ADDR_CTRL     = 8'(IDX_CTRL * 4);
  localparam logic [7:0]  ADDR_STATUS   = 8'(IDX_STATUS * 4);

  // threshold codes in 10 mV steps, band register: low [7:0], high [15:8]
  localparam int          BAND_LOW_LSB  = 0;
  localparam int          BAND_HIGH_LSB = 8;
  localparam logic [7:0]  LOW_DEFAULT   = 8'h2D;
  localparam logic [7:0]  HIGH_DEFAULT  = 8'h37;
  localparam logic [7:0]  HIGH_MIN      = 8'h19;
  localparam logic [7:0]  HIGH_MAX      = 8'h3C;
  localparam logic [7:0]  LOW_MIN       = 8'h14;
  localparam logic [7:0]  LOW_MAX       = 8'h37;
  localparam logic [15:0] CHAN_EN_RESET = 16'hFFFF;

  // ctrl register fields
  localparam int          CTRL_PAGE_BIT  = 0;
  localparam int          CTRL_INIT_LSB  = 8;
  localparam logic [5:0]  INIT_DEFAULT   = 6'h20;
  localparam logic [5:0]  DIV_MIN        = 6'h00;
  localparam logic [5:0]  DIV_MAX        = 6'h3F;

  // timing
  localparam int          CLK_MHZ        = 125;
  localparam int          PERIOD_US      = 20;
  localparam int          PERIOD_CYCLES  = PERIOD_US * CLK_MHZ;
  localparam int          DEB_CYCLES     = 4;
  localparam int          STRAP_SETTLE_US = 10;
  localparam int          STRAP_CYCLES   = STRAP_SETTLE_US * CLK_MHZ;

  // three-level strap code
  localparam logic [1:0]  LVL_SUPPLY     = 2'h0;
  localparam logic [1:0]  LVL_RESISTOR   = 2'h1;
  localparam logic [1:0]  LVL_GROUND     = 2'h2;

  // feedback output level code
  typedef enum logic [1:0] {
    FB_ZERO = 2'h0,
    FB_HALF = 2'h1,
    FB_ONE  = 2'h2
  } fb_level_t;

  // demand flags of one period
  typedef struct packed {
    logic raise;
    logic lower;
  } demand_t;

  // start-up sequencer
  typedef enum logic [1:0] {
    ST_SETTLE = 2'b00,
    ST_LATCH  = 2'b01,
    ST_RUN    = 2'b11
  } start_state_t;

endpackage : headroom_pkg

// [design/debounce.sv]
// debouncer for a small code: two-stage synchroniser then stable-count filter
`timescale 1ns/1ns
module debounce #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  // raw code and filtered code
  input  wire logic [W-1:0] i_raw,
  output logic      [W-1:0] o_code
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] code_reg;
  logic [2:0]   cnt_reg;
  logic [2:0]   cnt_next;
  wire          same = (sync_reg == code_reg);

  // count cycles the synchronised code differs from the held code
  assign cnt_next = same ? 3'h0 : cnt_reg + 3'h1;

  // synchroniser and filter, code updates after stable run
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
      code_reg <= '0;
      cnt_reg  <= 3'h0;
    end else begin
      meta_reg <= i_raw;
      sync_reg <= meta_reg;
      cnt_reg  <= cnt_next;
      if (cnt_next == 3'(headroom_pkg::DEB_CYCLES)) begin
        code_reg <= sync_reg;  // see R21
      end
    end
  end

  assign o_code = code_reg;

endmodule : debounce

// [design/headroom_feedback.sv]
// headroom loop decision logic with address strap decoder and register slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ns
module headroom_feedback (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // avalon-mm slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // analog comparator results per channel
  input  wire logic [15:0] i_chan_in_use,
  input  wire logic [15:0] i_sink_below_low,
  input  wire logic [15:0] i_sink_above_high,
  // feedback input window comparators and role strap
  input  wire logic        i_fbi_above_high,
  input  wire logic        i_fbi_above_low,
  input  wire logic        i_role_slave,
  // address strap three-level codes
  input  wire logic [1:0]  i_strap_a,
  input  wire logic [1:0]  i_strap_b,
  // outputs to analog and serial logic
  output logic      [7:0]  o_low_thresh,
  output logic      [7:0]  o_high_thresh,
  output logic             o_sample,
  output logic      [1:0]  o_fbo_level,
  output logic      [5:0]  o_divider,
  output logic      [3:0]  o_address,
  output logic             o_address_valid,
  output logic             o_is_master
);

  //--------------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------------
  logic [15:0] chan_en_reg;
  logic [15:0] band_reg;
  logic [15:0] ctrl_reg;
  logic [31:0] rdata_reg;
  logic        ack_reg;
  logic [15:0] period_reg;
  logic        sample_reg;
  logic [5:0]  div_reg;
  logic [5:0]  div_next;
  logic [1:0]  fbo_reg;
  logic        raise_reg;
  logic        lower_reg;
  logic [3:0]  addr_reg;
  logic        addr_valid_reg;
  logic        master_reg;
  logic [15:0] settle_reg;
  headroom_pkg::start_state_t st_reg;
  headroom_pkg::start_state_t st_next;

  //--------------------------------------------------------------------------
  // debounce of straps and feedback window
  //--------------------------------------------------------------------------
  logic [1:0] fbi_code;
  logic [4:0] strap_code;

  debounce #(.W(2)) u_fbi_deb (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_raw  ({i_fbi_above_high, i_fbi_above_low}),
    .o_code (fbi_code)
  );

  debounce #(.W(5)) u_strap_deb (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_raw  ({i_role_slave, i_strap_b, i_strap_a}),
    .o_code (strap_code)
  );

  //--------------------------------------------------------------------------
  // feedback input detector
  //--------------------------------------------------------------------------
  // above_low set and above_high clear: 0.75V to 1.2V window
  wire fbi_raise = fbi_code[0] & ~fbi_code[1];  // see R11
  // both comparators low: code 00 means below the lowest window
  wire fbi_lower = ~fbi_code[0] & ~fbi_code[1];  // see R12
  wire fbi_hold = ~fbi_raise & ~fbi_lower;  // see R13

  //--------------------------------------------------------------------------
  // channel aggregation over monitored set
  //--------------------------------------------------------------------------
  wire [15:0] monitored = i_chan_in_use & chan_en_reg;          // see R1 see R2
  wire        any_low   = |(i_sink_below_low & monitored);       // see R4
  wire        all_high  = (|monitored) &
                          ((i_sink_above_high & monitored) == monitored);  // see R5
  wire        want_up   = any_low | raise_reg;
  wire        want_down = ~want_up & all_high & lower_reg;

  //--------------------------------------------------------------------------
  // address decode
  //--------------------------------------------------------------------------
  function automatic logic [3:0] addr_decode(input logic [1:0] a, input logic [1:0] b,
                                             input logic page);
    logic [3:0] base;
    base = (4'(b) * 4'h3) + 4'(a);  // widen first so 2*3 cannot wrap
    if (!page) begin
      addr_decode = base;                                        // see R17
    end else if (base == 4'h8) begin
      addr_decode = 4'h8;                                        // see R18
    end else begin
      addr_decode = base + 4'h8;                                 // see R18
    end
  endfunction : addr_decode

  wire [3:0] addr_calc = addr_decode(strap_code[1:0], strap_code[3:2],
                                     ctrl_reg[headroom_pkg::CTRL_PAGE_BIT]);

  //--------------------------------------------------------------------------
  // start-up sequencer
  //--------------------------------------------------------------------------
  wire settle_done = (settle_reg == 16'(headroom_pkg::STRAP_CYCLES));
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      headroom_pkg::ST_SETTLE: if (settle_done) st_next = headroom_pkg::ST_LATCH;
      headroom_pkg::ST_LATCH:  st_next = headroom_pkg::ST_RUN;
      headroom_pkg::ST_RUN:    st_next = headroom_pkg::ST_RUN;
      default:                 st_next = headroom_pkg::ST_SETTLE;
    endcase
  end
  wire running = (st_reg == headroom_pkg::ST_RUN);

  // sequencer, strap capture held until reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg         <= headroom_pkg::ST_SETTLE;
      settle_reg     <= 16'h0000;
      addr_reg       <= 4'h0;
      addr_valid_reg <= 1'b0;
      master_reg     <= 1'b1;
    end else begin
      st_reg <= st_next;
      if (!settle_done) settle_reg <= settle_reg + 16'h0001;
      if (st_reg == headroom_pkg::ST_LATCH) begin
        addr_reg       <= addr_calc;                             // see R19
        addr_valid_reg <= 1'b1;
        master_reg     <= ~strap_code[4];                        // see R9
      end
    end
  end

  //--------------------------------------------------------------------------
  // monitoring period tick
  //--------------------------------------------------------------------------
  wire period_end = (period_reg == 16'(headroom_pkg::PERIOD_CYCLES - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst || !running) begin
      period_reg <= 16'h0000;
      sample_reg <= 1'b0;
    end else begin
      period_reg <= period_end ? 16'h0000 : period_reg + 16'h0001;
      sample_reg <= period_end;                                  // see R3
    end
  end

  // latch feedback flags once per period
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      raise_reg <= 1'b0;
      lower_reg <= 1'b0;
    end else if (period_end) begin
      raise_reg <= fbi_raise & ~fbi_hold;
      lower_reg <= fbi_lower & ~fbi_hold;
    end
  end

  //--------------------------------------------------------------------------
  // divider counter and feedback output
  //--------------------------------------------------------------------------
  // saturating step, only master moves the rail
  always_comb begin
    div_next = div_reg;
    if (master_reg) begin                                        // see R10
      if (want_up && div_reg != headroom_pkg::DIV_MIN) begin
        div_next = div_reg - 6'h01;                              // see R15 see R22
      end else if (want_down && div_reg != headroom_pkg::DIV_MAX) begin
        div_next = div_reg + 6'h01;                              // see R16 see R22
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_reg <= headroom_pkg::INIT_DEFAULT;
      fbo_reg <= headroom_pkg::FB_HALF;
    end else if (!running) begin
      div_reg <= ctrl_reg[headroom_pkg::CTRL_INIT_LSB +: 6];     // see R8
      fbo_reg <= headroom_pkg::FB_HALF;
    end else if (sample_reg) begin
      div_reg <= div_next;
      if (master_reg) begin
        fbo_reg <= headroom_pkg::FB_HALF;
      end else if (want_up) begin
        fbo_reg <= headroom_pkg::FB_ONE;                         // see R14
      end else if (want_down) begin
        fbo_reg <= headroom_pkg::FB_ZERO;                        // see R14
      end else begin
        fbo_reg <= headroom_pkg::FB_HALF;                        // see R14
      end
    end
  end

  //--------------------------------------------------------------------------
  // avalon-mm slave, one wait cycle then answer
  //--------------------------------------------------------------------------
  wire        req      = (i_avs_read | i_avs_write) & ~ack_reg;
  wire        hit_en   = (i_avs_address == headroom_pkg::ADDR_CHAN_EN);
  wire        hit_band = (i_avs_address == headroom_pkg::ADDR_BAND);
  wire        hit_ctrl = (i_avs_address == headroom_pkg::ADDR_CTRL);
  wire        hit_stat = (i_avs_address == headroom_pkg::ADDR_STATUS);
  wire [15:0] wmask    = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [15:0] wband    = (band_reg & ~wmask) | (i_avs_writedata[15:0] & wmask);
  wire [7:0]  wlow     = wband[headroom_pkg::BAND_LOW_LSB +: 8];
  wire [7:0]  whigh    = wband[headroom_pkg::BAND_HIGH_LSB +: 8];
  wire [7:0]  low_c    = (wlow < headroom_pkg::LOW_MIN) ? headroom_pkg::LOW_MIN :
                         (wlow > headroom_pkg::LOW_MAX) ? headroom_pkg::LOW_MAX : wlow;
  wire [7:0]  high_c   = (whigh < headroom_pkg::HIGH_MIN) ? headroom_pkg::HIGH_MIN :
                         (whigh > headroom_pkg::HIGH_MAX) ? headroom_pkg::HIGH_MAX : whigh;
  wire [31:0] status_w = {8'h00, addr_valid_reg, master_reg, raise_reg, lower_reg,
                          addr_reg, 2'h0, div_reg, 6'h00, fbo_reg};
  wire [31:0] rd_mux   = hit_en   ? {16'h0000, chan_en_reg} :
                         hit_band ? {16'h0000, band_reg} :
                         hit_ctrl ? {16'h0000, ctrl_reg} :
                         hit_stat ? status_w : 32'h0000_0000;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_reg     <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      chan_en_reg <= headroom_pkg::CHAN_EN_RESET;
      band_reg    <= {headroom_pkg::HIGH_DEFAULT, headroom_pkg::LOW_DEFAULT};
      ctrl_reg    <= {2'h0, headroom_pkg::INIT_DEFAULT, 8'h00};
    end else begin
      ack_reg <= req;
      if (req && i_avs_read) rdata_reg <= rd_mux;
      if (req && i_avs_write && hit_en) begin
        chan_en_reg <= (chan_en_reg & ~wmask) | (i_avs_writedata[15:0] & wmask);  // see R2
      end
      if (req && i_avs_write && hit_band) begin
        band_reg <= {high_c, low_c};                             // see R6
      end
      if (req && i_avs_write && hit_ctrl) begin
        ctrl_reg <= (ctrl_reg & ~wmask) | (i_avs_writedata[15:0] & wmask);
      end
    end
  end

  //--------------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------------
  logic [7:0] low_out_reg;
  logic [7:0] high_out_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      low_out_reg  <= headroom_pkg::LOW_DEFAULT;
      high_out_reg <= headroom_pkg::HIGH_DEFAULT;
    end else begin
      low_out_reg  <= band_reg[headroom_pkg::BAND_LOW_LSB +: 8];
      high_out_reg <= band_reg[headroom_pkg::BAND_HIGH_LSB +: 8];
    end
  end

  logic wait_reg;
  always_ff @(posedge i_clk) begin
    if (i_rst) wait_reg <= 1'b1;
    else       wait_reg <= ~req;
  end

  assign o_avs_readdata    = rdata_reg;
  assign o_avs_waitrequest = wait_reg;
  assign o_low_thresh      = low_out_reg;
  assign o_high_thresh     = high_out_reg;
  assign o_sample          = sample_reg;
  assign o_fbo_level       = fbo_reg;
  assign o_divider         = div_reg;
  assign o_address         = addr_reg;
  assign o_address_valid   = addr_valid_reg;
  assign o_is_master       = master_reg;

endmodule : headroom_feedback

// [tb/slave_feedback_model.sv]
// slave driver chip model feeding the master's feedback window comparators
`timescale 1ns/1ns
module slave_feedback_model (
  // demand reported by the slave
  input  wire headroom_pkg::demand_t i_demand,
  // window comparator results at the feedback input
  output logic                       o_above_high,
  output logic                       o_above_low
);
  // raise drives 1V, lower 0V, anything else the mid level
  assign o_above_low  = i_demand.raise || !i_demand.lower;
  assign o_above_high = !i_demand.raise && !i_demand.lower;
endmodule : slave_feedback_model

// [tb/headroom_feedback_properties.sv]
// concurrent checks on the headroom feedback block ports
`timescale 1ns/1ns
module headroom_feedback_properties (
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_rst,
  // bus handshake
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  // loop and address outputs
  input wire logic [7:0] o_low_thresh,
  input wire logic [7:0] o_high_thresh,
  input wire logic       o_sample,
  input wire logic [1:0] o_fbo_level,
  input wire logic [5:0] o_divider,
  input wire logic [3:0] o_address,
  input wire logic       o_address_valid,
  input wire logic       o_is_master
);
  int   gap_reg;
  logic seen_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // cycles since the last sample pulse
  always_ff @(posedge i_clk) begin
    gap_reg  <= (i_rst || o_sample) ? 0 : gap_reg + 1;
    seen_reg <= !i_rst && (seen_reg || o_sample);
  end
  // request taken, then one answer cycle
  sequence req_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence ack_s;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  bus_answer_a: assert property (req_s |=> ack_s)
    else $error("bus answer missing or too long");
  reset_state_a: assert property ($fell(i_rst) |-> o_avs_waitrequest && !o_address_valid
    && o_divider == headroom_pkg::INIT_DEFAULT && o_low_thresh == headroom_pkg::LOW_DEFAULT
    && o_high_thresh == headroom_pkg::HIGH_DEFAULT) else $error("wrong state after reset");
  band_range_a: assert property (o_high_thresh inside {[headroom_pkg::HIGH_MIN:
    headroom_pkg::HIGH_MAX]} && o_low_thresh inside {[headroom_pkg::LOW_MIN:headroom_pkg::LOW_MAX]})
    else $error("band threshold out of range");
  sample_pulse_a: assert property (o_sample |=> !o_sample)
    else $error("sample pulse longer than one cycle");
  sample_gap_a: assert property (o_sample && seen_reg |->
    gap_reg == headroom_pkg::PERIOD_CYCLES - 1) else $error("sample period wrong");
  divider_step_a: assert property ($past(o_address_valid) && $changed(o_divider) |-> $past(o_sample)
    && ((o_divider == $past(o_divider) + 6'h01 && $past(o_divider) != 6'h3F)
    || (o_divider == $past(o_divider) - 6'h01 && $past(o_divider) != 6'h00)))
    else $error("divider moved wrongly");
  slave_hold_a: assert property ($past(o_address_valid) && !o_is_master |-> $stable(o_divider))
    else $error("slave moved its divider");
  master_fbo_a: assert property (o_is_master && $past(o_is_master) |-> $stable(o_fbo_level))
    else $error("master changed level output");
  fbo_step_a: assert property ($past(o_address_valid) && $changed(o_fbo_level) |-> $past(o_sample)
    && o_fbo_level != 2'h3) else $error("level output changed off period");
  address_hold_a: assert property ($past(o_address_valid) |-> o_address_valid
    && $stable(o_address) && $stable(o_is_master)) else $error("address not held");
endmodule : headroom_feedback_properties

bind headroom_feedback headroom_feedback_properties u_props (.i_clk, .i_rst, .i_avs_read,
  .i_avs_write, .o_avs_waitrequest, .o_low_thresh, .o_high_thresh, .o_sample, .o_fbo_level,
  .o_divider, .o_address, .o_address_valid, .o_is_master);

// [tb/headroom_feedback_tb.sv]
// self-checking bench for the headroom feedback block with a behavioural model
`timescale 1ns/1ns
module headroom_feedback_tb;
  logic                  i_clk = 1'b0, i_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]            avs_address = 8'h00, low_th, high_th;
  logic [31:0]           avs_wdata = 32'h0, avs_rdata;
  logic [15:0]           in_use = 16'hFFFF, below = 16'h0000, above = 16'h0000;
  headroom_pkg::demand_t demand = 2'b00;
  logic [1:0]            strap_a = 2'h0, strap_b = 2'h0, feedback_output_pin;
  logic [5:0]            divider;
  logic [3:0]            address;
  logic                  role_slave = 1'b0, fbi_high, fbi_low, avs_wait, sample, valid, master;
  int                    errors = 0, cmp_count = 0, cycles = 0;

  headroom_feedback DUT (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_wdata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
    .i_chan_in_use(in_use), .i_sink_below_low(below), .i_sink_above_high(above),
    .i_fbi_above_high(fbi_high), .i_fbi_above_low(fbi_low), .i_role_slave(role_slave),
    .i_strap_a(strap_a), .i_strap_b(strap_b), .o_low_thresh(low_th), .o_high_thresh(high_th),
    .o_sample(sample), .o_fbo_level(feedback_output_pin), .o_divider(divider), .o_address(address),
    .o_address_valid(valid), .o_is_master(master));
  slave_feedback_model u_slave (.i_demand(demand), .o_above_high(fbi_high), .o_above_low(fbi_low));

  // free-running clock
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // hang guard
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      $display("unexpected %0t run timed out", $time);
      summarize();
    end
  end

  task summarize;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // one bus transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_wdata <= d;
    // sample waitrequest at the edge itself, release at the answering edge
    do begin
      @(posedge i_clk);
      n++;
    end while (avs_wait !== 1'b0);
    q = avs_rdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    check(n, 32'h2, "bus answer");
  endtask : bus

  task wait_cond(input int lim, input bit for_valid);
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while ((for_valid ? valid : sample) !== 1'b1 && n < lim);
    check(32'(n < lim), 32'h1, "wait limit");
  endtask : wait_cond

  // random periods against the integer model of the loop
  task run_periods(input logic sl, input logic [15:0] en, input int div0);
    logic [15:0] u, b, h, mon;
    headroom_pkg::demand_t d;
    int k, div_m, fbo_m;
    div_m = div0;
    wait_cond(2600, 0);
    for (int p = 0; p < 5; p++) begin
      k = $urandom % 4;
      u = (k == 3) ? 16'($urandom) : 16'hFFFF;
      b = (k == 1) ? 16'(1 << ($urandom % 16)) : 16'h0000;
      h = ((k == 0) ? 16'hFFFF : (16'($urandom) | 16'hF0F0)) & ~b;
      d = (k == 0) ? 2'b01 : 2'(1 << ($urandom % 3));
      @(posedge i_clk);
      in_use <= u;
      below <= b;
      above <= h;
      demand <= d;
      mon = u & en;
      fbo_m = 1;
      if ((|(b & mon)) || d.raise) begin
        fbo_m = 2;
        div_m = (div_m > 0) ? div_m - 1 : 0;
      end else if (mon != 0 && (h & mon) == mon && d.lower) begin
        fbo_m = 0;
        div_m = (div_m < 63) ? div_m + 1 : 63;
      end
      if (sl) div_m = div0;
      wait_cond(2600, 0);
      // divider and level output move on the edge after the pulse
      @(posedge i_clk);
      #1;
      check(divider, div_m, "divider");
      if (sl) check(feedback_output_pin, fbo_m, "level output");
    end
  endtask : run_periods

  // reset, start-up and loop runs
  initial begin
    logic [31:0] q;
    logic [1:0]  sa, sb;
    logic        pg, sl;
    logic [5:0]  init;
    logic [15:0] en;
    int          ea;
    void'($urandom(32'hA6259131));
    for (int i = 0; i < 10; i++) begin
      sa = 2'($urandom % 3);
      sb = 2'($urandom % 3);
      pg = 1'($urandom);
      sl = (i < 4) ? 1'(i % 2) : 1'($urandom);
      init = (i == 2) ? 6'h3E : 6'($urandom % 4);
      en = (i == 3) ? 16'($urandom) : 16'hFFFF;
      @(posedge i_clk);
      i_rst <= 1'b1;
      strap_a <= sa;
      strap_b <= sb;
      role_slave <= sl;
      below <= 16'h0000;
      above <= 16'h0000;
      demand <= 2'b00;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      if (i == 0) begin
        bus(0, headroom_pkg::ADDR_CHAN_EN, 0, q);
        check(q, 32'h0000FFFF, "enable reset");
        bus(1, headroom_pkg::ADDR_BAND, 32'h0000FF00, q);
        bus(0, headroom_pkg::ADDR_BAND, 0, q);
        check(q, 32'h00003C14, "band clamp");
        bus(1, headroom_pkg::ADDR_BAND, 32'h0000281E, q);
        @(posedge i_clk);
        #1;
        check({high_th, low_th}, 32'h0000281E, "band outputs");
        bus(1, 8'h40, 32'hFFFFFFFF, q);
        bus(0, 8'h40, 0, q);
        check(q, 32'h0, "unmapped read");
      end
      bus(1, headroom_pkg::ADDR_CTRL, 32'({init, 7'h00, pg}), q);
      bus(1, headroom_pkg::ADDR_CHAN_EN, 32'(en), q);
      wait_cond(1500, 1);
      ea = pg ? ((sa == 2 && sb == 2) ? 8 : 8 + 3 * sb + sa) : 3 * sb + sa;
      check(address, ea, "address");
      check(master, !sl, "role");
      check(divider, init, "initial divider");
      @(posedge i_clk);
      strap_a <= 2'(2 - sa);
      strap_b <= 2'(2 - sb);
      repeat (20) @(posedge i_clk);
      check(address, ea, "address held");
      if (i < 4) run_periods(sl, en, init);
    end
    summarize();
  end
endmodule : headroom_feedback_tb
